/* dv/glps_host.sv */
// host model driving the axi4-lite register bus
`timescale 1ns/100ps
`default_nettype none
module glps_host (
    // clock
    input wire aclk,
    // write channels
    output logic s_axi_awvalid,
    input wire s_axi_awready,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_wvalid,
    input wire s_axi_wready,
    output logic [31:0] s_axi_wdata,
    input wire s_axi_bvalid,
    output logic s_axi_bready,
    input wire [1:0] s_axi_bresp,
    // read channels
    output logic s_axi_arvalid,
    input wire s_axi_arready,
    output logic [7:0] s_axi_araddr,
    input wire s_axi_rvalid,
    output logic s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp
);
initial begin
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = 8'h0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = 8'h0;
    s_axi_rready = 1'b0;
end
////////////////////////////////////////////////////////////////////////////
// one write, address and data offered together, released lines inverted
task automatic wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] resp);
    logic aw_p;
    logic w_p;
    begin
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (aw_p && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
                aw_p = 1'b0;
            end
            if (w_p && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
                w_p = 1'b0;
            end
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    end
endtask
// one read
task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] resp);
    begin
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    end
endtask
endmodule
`default_nettype wire

/* dv/glps_regs_assertions.sv */
// concurrent checks on the register block ports
`timescale 1ns/100ps
`default_nettype none
module glps_regs_chk #(parameter TAP_W = 8) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // register bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // synthesiser side
    input wire [TAP_W-1:0] taps_per_increment,
    input wire ratio_update,
    input wire [15:0] phase_shift,
    input wire [TAP_W+15:0] phase_taps,
    input wire [15:0] deviation_limit,
    input wire [31:0] clock_ratio_numerator
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////
wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer not on time");
rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |-> ##2 s_axi_rvalid) else $error("read answer not on time");
r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
rd_upper_a: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:16] == 16'h0) else $error("upper read bits set");
phase_taps_a: assert property (phase_taps ==
    phase_shift * $past(taps_per_increment)) else $error("taps wrong");
limit_rst_a: assert property ($rose(aresetn)
    |-> deviation_limit == 16'h000b) else $error("limit reset wrong");
ratio_hold_a: assert property (!ratio_update && $past(aresetn, 2)
    |=> $stable(clock_ratio_numerator)) else $error("ratio moved");
cover property (ratio_update);
cover property (s_axi_rvalid && s_axi_rready);
cover property (s_axi_bvalid && s_axi_awvalid);
endmodule
bind glps_regs glps_regs_chk #(.TAP_W(TAP_W)) i_chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .taps_per_increment, .ratio_update,
    .phase_shift, .phase_taps, .deviation_limit, .clock_ratio_numerator);
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the register block
`timescale 1ns/100ps
`default_nettype none
module tb;
logic aclk, aresetn, ratio_update;
logic [6:0] st;
logic [15:0] ref_deviation, lim, ph;
logic [7:0] taps_per_increment;
logic [31:0] std_ratio_numerator, std_ratio_denominator, d, en;
logic [31:0] v [4];
logic [1:0] r;
wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
wire s_axi_rvalid, s_axi_rready, video_lock_ok;
wire [7:0] s_axi_awaddr, s_axi_araddr;
wire [31:0] s_axi_wdata, s_axi_rdata, clock_ratio_numerator;
wire [31:0] clock_ratio_denominator, rdata_na;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [15:0] phase_shift, deviation_limit;
wire [23:0] phase_taps;
int n_errors = 0;
int n_checks = 0;
int seed;
glps_regs #(.HAS_AUDIO(1), .TAP_W(8)) i_dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .ref_present(st[0]), .ref_h_polarity(st[1]), .ref_v_polarity(st[2]),
    .ref_blank_timing(st[3]), .ref_digital_blank(st[4]),
    .audio_pll_locked(st[5]), .video_pll_locked(st[6]), .ref_deviation,
    .taps_per_increment, .std_ratio_numerator, .std_ratio_denominator,
    .ratio_update, .phase_shift, .phase_taps, .deviation_limit,
    .clock_ratio_numerator, .clock_ratio_denominator, .video_lock_ok);
// variant without audio clock generation, same bus traffic
glps_regs #(.HAS_AUDIO(0), .TAP_W(8)) i_dut_na (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready(), .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready(), .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_bvalid(), .s_axi_bready, .s_axi_bresp(),
    .s_axi_arvalid, .s_axi_arready(), .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid(), .s_axi_rready, .s_axi_rdata(rdata_na),
    .s_axi_rresp(),
    .ref_present(st[0]), .ref_h_polarity(st[1]), .ref_v_polarity(st[2]),
    .ref_blank_timing(st[3]), .ref_digital_blank(st[4]),
    .audio_pll_locked(st[5]), .video_pll_locked(st[6]), .ref_deviation,
    .taps_per_increment, .std_ratio_numerator, .std_ratio_denominator,
    .ratio_update, .phase_shift(), .phase_taps(), .deviation_limit(),
    .clock_ratio_numerator(), .clock_ratio_denominator(),
    .video_lock_ok());
glps_host i_host (.aclk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
////////////////////////////////////////////////////////////////////////////
task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
        n_errors++;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
endtask
task rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] e);
    i_host.rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, e});
endtask
task wrc(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
    i_host.wr(a, x, r);
    chk({30'h0, r}, {30'h0, e});
endtask
function logic [15:0] stat(input logic [6:0] s, input logic [15:0] dv);
    return {11'h0, s[0] & s[1], s[0] & s[2] & ~s[4], s[0] & s[3], s[5],
        s[6] & (dv <= lim)};
endfunction
task results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
end
initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    results;
end
initial begin
    seed = $urandom(99);
    {aresetn, ratio_update, st, ref_deviation, taps_per_increment} = '0;
    std_ratio_numerator = $urandom | 32'h1;
    std_ratio_denominator = $urandom | 32'h1;
    lim = 16'h000b;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    en = std_ratio_numerator;
    chk(clock_ratio_numerator, en);
    chk(clock_ratio_denominator, std_ratio_denominator);
    rdc(8'h74, 32'h0, 2'h0);
    rdc(8'h78, {16'h0, lim}, 2'h0);
    rdc(8'h84, {16'h0, en[31:16]}, 2'h0);
    for (int i = 0; i < 5; i++) begin
        ph = (i == 4) ? 16'h0 : 16'($urandom);
        lim = 16'($urandom % 24);
        taps_per_increment <= 8'($urandom);
        wrc(8'h74, {16'hffff, ph}, 2'h0);
        wrc(8'h78, {16'h0, lim}, 2'h0);
        rdc(8'h74, {16'h0, ph}, 2'h0);
        rdc(8'h78, {16'h0, lim}, 2'h0);
        #1;
        chk(phase_shift, ph);
        chk(phase_taps, 24'(ph) * taps_per_increment);
        chk(deviation_limit, lim);
    end
    for (int i = 0; i < 16; i++) begin
        @(posedge aclk);
        st <= (i < 2) ? {7{i[0]}} : 7'($urandom);
        ref_deviation <= 16'($urandom % 32);
        repeat (10) @(posedge aclk);
        rdc(8'h7c, {16'h0, stat(st, ref_deviation)}, 2'h0);
        chk(rdata_na, {16'h0, stat(st, ref_deviation) | 16'h0002});
        chk(video_lock_ok, st[6] & (ref_deviation <= lim));
        wrc(8'h7c, 32'hffff_ffff, 2'h0);
        rdc(8'h7c, {16'h0, stat(st, ref_deviation)}, 2'h0);
    end
    rdc(8'h00, 32'h0, 2'h3);
    wrc(8'h90, 32'h1234, 2'h3);
    rdc(8'h90, 32'h0, 2'h3);
    for (int k = 0; k < 2; k++) begin
        for (int i = 0; i < 4; i++) begin
            v[i] = k ? 32'h0 : {16'h0, 16'($urandom)};
            wrc(8'h80 + 8'(4 * i), v[i], 2'h0);
            rdc(8'h80 + 8'(4 * i), v[i], 2'h0);
        end
        #1;
        chk(clock_ratio_numerator, en);
        @(posedge aclk);
        ratio_update <= 1'b1;
        @(posedge aclk);
        ratio_update <= 1'b0;
        @(posedge aclk);
        #1;
        en = k ? std_ratio_numerator : {v[1][15:0], v[0][15:0]};
        chk(clock_ratio_numerator, en);
        chk(clock_ratio_denominator, k ? std_ratio_denominator
            : {v[3][15:0], v[2][15:0]});
    end
    results;
end
endmodule
`default_nettype wire

/* rtl/glps_axil_slave.v */
// axi4-lite slave front end, one write and one read at a time
`timescale 1ns/100ps
`default_nettype none
`include "glps_map.vh"

module glps_axil_slave (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write address
    input wire awvalid,
    output wire awready,
    input wire [`GLPS_ADDR_W-1:0] awaddr,
    input wire [2:0] awprot,
    // write data
    input wire wvalid,
    output wire wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    // write response
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    // read address
    input wire arvalid,
    output wire arready,
    input wire [`GLPS_ADDR_W-1:0] araddr,
    input wire [2:0] arprot,
    // read data
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    // register file side
    output wire wr_en,
    output reg [`GLPS_IDX_W-1:0] wr_idx,
    output reg [15:0] wr_data,
    output reg [1:0] wr_strb,
    input wire wr_err,
    output wire rd_en,
    output reg [`GLPS_IDX_W-1:0] rd_idx,
    input wire [15:0] rd_data,
    input wire rd_err
);

reg aw_got_q;
reg w_got_q;
reg ar_got_q;

assign awready = ~aw_got_q & ~bvalid;
assign wready = ~w_got_q & ~bvalid;
assign wr_en = aw_got_q & w_got_q & ~bvalid;
assign arready = ~ar_got_q & ~rvalid;
assign rd_en = ar_got_q & ~rvalid;

////////////////////////////////////////////////////////////////////////////
// write path, address and data in either order
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        wr_idx <= {`GLPS_IDX_W{1'b0}};
        wr_data <= 16'h0000;
        wr_strb <= 2'h0;
        bvalid <= 1'b0;
        bresp <= `GLPS_RESP_OKAY;
    end else begin
        if (awvalid && awready) begin
            aw_got_q <= 1'b1;
            wr_idx <= awaddr[`GLPS_IDX_W+1:2];
        end
        if (wvalid && wready) begin
            w_got_q <= 1'b1;
            wr_data <= wdata[15:0];
            wr_strb <= wstrb[1:0];
        end
        if (wr_en) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_err ? `GLPS_RESP_DECERR : `GLPS_RESP_OKAY;
        end
        if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// read path
always @(posedge aclk) begin
    if (!aresetn) begin
        ar_got_q <= 1'b0;
        rd_idx <= {`GLPS_IDX_W{1'b0}};
        rvalid <= 1'b0;
        rdata <= 32'h0000_0000;
        rresp <= `GLPS_RESP_OKAY;
    end else begin
        if (arvalid && arready) begin
            ar_got_q <= 1'b1;
            rd_idx <= araddr[`GLPS_IDX_W+1:2];
        end
        if (rd_en) begin
            ar_got_q <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {16'h0000, rd_data};
            rresp <= rd_err ? `GLPS_RESP_DECERR : `GLPS_RESP_OKAY;
        end
        if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

/* rtl/glps_map.vh */
// register indices, field positions, reset values and codes of the block
`ifndef GLPS_MAP_VH
`define GLPS_MAP_VH

// register indices, byte address is four times the index
`define GLPS_ADDR_W 8
`define GLPS_IDX_W 6
`define GLPS_IDX_PHASE 6'h1d
`define GLPS_IDX_DELTA 6'h1e
`define GLPS_IDX_STAT 6'h1f
`define GLPS_IDX_NUM_LO 6'h20
`define GLPS_IDX_NUM_HI 6'h21
`define GLPS_IDX_DEN_LO 6'h22
`define GLPS_IDX_DEN_HI 6'h23
`define GLPS_IDX_RATIO_TOP 4'h8

// ratio half slots, low two index bits
`define GLPS_HALF_NUM_LO 0
`define GLPS_HALF_NUM_HI 1
`define GLPS_HALF_DEN_LO 2
`define GLPS_HALF_DEN_HI 3
`define GLPS_HALF_N 4

// reset values
`define GLPS_RST_PHASE 16'h0000
`define GLPS_RST_DELTA 16'h000b
`define GLPS_RST_HALF 16'h0000
`define GLPS_RST_RATIO 32'h0000_0000

// status field positions
`define GLPS_BIT_VLOCK 0
`define GLPS_BIT_ALOCK 1
`define GLPS_BIT_BLANK 2
`define GLPS_BIT_VPOL 3
`define GLPS_BIT_HPOL 4
`define GLPS_STAT_W 5

// positions in the synchronised input vector
`define GLPS_SY_PRES 0
`define GLPS_SY_HPOL 1
`define GLPS_SY_VPOL 2
`define GLPS_SY_BLANK 3
`define GLPS_SY_DIGB 4
`define GLPS_SY_ALOCK 5
`define GLPS_SY_VLOCK 6
`define GLPS_SY_N 7

// bus answers
`define GLPS_RESP_OKAY 2'h0
`define GLPS_RESP_DECERR 2'h3

`endif

/* rtl/glps_regs.v */
// genlock phase, reference deviation, lock status and clock ratio registers
//
// Summary of operation
// - phase offset count shifts output clock phase
// - increment size follows current video clock
// - deviation limit register, resets to 000b
// - status bit4 h sync polarity, zero unreferenced
// - bit3 v polarity, zero unreferenced or digital
// - bit2 blanking versus sync timing, zero unreferenced
// - bit1 audio clock locked to video clock
// - without audio generation bit1 reads high
// - bit0 video lock; bits 15-5 reserved
// - nonzero numerator sets video clock ratio
// - nonzero denominator sets video clock ratio
// - ratio words split low and high halves
// - ratio defaults follow selected video standard
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "glps_map.vh"

module glps_regs #(
    parameter HAS_AUDIO = 1,
    parameter TAP_W = 8
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [`GLPS_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    // axi4-lite write data
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // axi4-lite write response
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    output wire [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [`GLPS_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    // axi4-lite read data
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    // reference detector and pll state, asynchronous
    input wire ref_present,
    input wire ref_h_polarity,
    input wire ref_v_polarity,
    input wire ref_blank_timing,
    input wire ref_digital_blank,
    input wire audio_pll_locked,
    input wire video_pll_locked,
    // measured reference deviation, aclk domain
    input wire [15:0] ref_deviation,
    // delay taps per phase increment at the current video clock
    input wire [TAP_W-1:0] taps_per_increment,
    // standard defaults of the ratio, aclk domain
    input wire [31:0] std_ratio_numerator,
    input wire [31:0] std_ratio_denominator,
    // ratio update strobe from the control register
    input wire ratio_update,
    // to the clock synthesiser
    output reg [15:0] phase_shift,
    output reg [TAP_W+15:0] phase_taps,
    output reg [15:0] deviation_limit,
    output reg [31:0] clock_ratio_numerator,
    output reg [31:0] clock_ratio_denominator,
    output reg video_lock_ok
);

////////////////////////////////////////////////////////////////////////////
// declarations
wire wr_en;
wire [`GLPS_IDX_W-1:0] wr_idx;
wire [15:0] wr_data;
wire [1:0] wr_strb;
wire rd_en;
wire [`GLPS_IDX_W-1:0] rd_idx;
reg [15:0] rd_data;
reg rd_err;
reg wr_err;

reg [15:0] phase_q;
reg [15:0] delta_q;
reg [`GLPS_STAT_W-1:0] stat_q;
reg loaded_q;

wire [`GLPS_SY_N-1:0] raw_in;
wire [`GLPS_SY_N-1:0] sy;
wire [15:0] half_view [0:`GLPS_HALF_N-1];
wire [15:0] std_half [0:`GLPS_HALF_N-1];
wire wr_ratio;
wire [31:0] num_view;
wire [31:0] den_view;

////////////////////////////////////////////////////////////////////////////
// bus front end
glps_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .awaddr(s_axi_awaddr),
    .awprot(s_axi_awprot),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .bresp(s_axi_bresp),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .araddr(s_axi_araddr),
    .arprot(s_axi_arprot),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_err(rd_err)
);

// byte lane merge of a 16-bit register
function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0] strb;
    begin
        merge16 = {strb[1] ? nw[15:8] : old[15:8],
                   strb[0] ? nw[7:0] : old[7:0]};
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// three stage synchronisers, change accepted when stages two and three agree
assign raw_in[`GLPS_SY_PRES] = ref_present;
assign raw_in[`GLPS_SY_HPOL] = ref_h_polarity;
assign raw_in[`GLPS_SY_VPOL] = ref_v_polarity;
assign raw_in[`GLPS_SY_BLANK] = ref_blank_timing;
assign raw_in[`GLPS_SY_DIGB] = ref_digital_blank;
assign raw_in[`GLPS_SY_ALOCK] = audio_pll_locked;
assign raw_in[`GLPS_SY_VLOCK] = video_pll_locked;

genvar gi;
generate
    for (gi = 0; gi < `GLPS_SY_N; gi = gi + 1) begin : g_sync
        reg s1_q;
        reg s2_q;
        reg s3_q;
        reg hold_q;
        always @(posedge aclk) begin
            if (!aresetn) begin
                s1_q <= 1'b0;
                s2_q <= 1'b0;
                s3_q <= 1'b0;
                hold_q <= 1'b0;
            end else begin
                s1_q <= raw_in[gi];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q) begin
                    hold_q <= s3_q;
                end
            end
        end
        assign sy[gi] = hold_q;
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// phase offset and deviation limit
always @(posedge aclk) begin
    if (!aresetn) begin
        phase_q <= `GLPS_RST_PHASE;
        delta_q <= `GLPS_RST_DELTA;
    end else if (wr_en) begin
        if (wr_idx == `GLPS_IDX_PHASE) begin
            phase_q <= merge16(phase_q, wr_data, wr_strb);
        end
        if (wr_idx == `GLPS_IDX_DELTA) begin
            delta_q <= merge16(delta_q, wr_data, wr_strb);
        end
    end
end

// delay applied is the count times the taps one increment spans
always @(posedge aclk) begin
    if (!aresetn) begin
        phase_shift <= `GLPS_RST_PHASE;
        phase_taps <= {(TAP_W+16){1'b0}};
        deviation_limit <= `GLPS_RST_DELTA;
    end else begin
        phase_shift <= phase_q;
        phase_taps <= phase_q * taps_per_increment;
        deviation_limit <= delta_q;
    end
end

////////////////////////////////////////////////////////////////////////////
// ratio halves, each falls back to the standard default until written
assign std_half[`GLPS_HALF_NUM_LO] = std_ratio_numerator[15:0];
assign std_half[`GLPS_HALF_NUM_HI] = std_ratio_numerator[31:16];
assign std_half[`GLPS_HALF_DEN_LO] = std_ratio_denominator[15:0];
assign std_half[`GLPS_HALF_DEN_HI] = std_ratio_denominator[31:16];
assign wr_ratio = wr_en & (wr_idx[5:2] == `GLPS_IDX_RATIO_TOP);

generate
    for (gi = 0; gi < `GLPS_HALF_N; gi = gi + 1) begin : g_half
        reg [15:0] val_q;
        reg wr_q;
        always @(posedge aclk) begin
            if (!aresetn) begin
                val_q <= `GLPS_RST_HALF;
                wr_q <= 1'b0;
            end else if (wr_ratio && wr_idx[1:0] == gi) begin
                val_q <= merge16(half_view[gi], wr_data,
                                 wr_strb);
                wr_q <= 1'b1;
            end
        end
        assign half_view[gi] = wr_q ? val_q :
                               std_half[gi];
    end
endgenerate

assign num_view = {half_view[`GLPS_HALF_NUM_HI],
                   half_view[`GLPS_HALF_NUM_LO]};
assign den_view = {half_view[`GLPS_HALF_DEN_HI],
                   half_view[`GLPS_HALF_DEN_LO]};

// new ratio reaches the synthesiser only on update; zero keeps default
always @(posedge aclk) begin
    if (!aresetn) begin
        clock_ratio_numerator <= `GLPS_RST_RATIO;
        clock_ratio_denominator <= `GLPS_RST_RATIO;
        loaded_q <= 1'b0;
    end else if (ratio_update || !loaded_q) begin
        loaded_q <= 1'b1;
        clock_ratio_numerator <= (num_view != 32'h0000_0000) ?
            num_view : std_ratio_numerator;
        clock_ratio_denominator <= (den_view != 32'h0000_0000) ?
            den_view : std_ratio_denominator;
    end
end

////////////////////////////////////////////////////////////////////////////
// status, rebuilt every cycle and never written by the host
always @(posedge aclk) begin
    if (!aresetn) begin
        stat_q <= {`GLPS_STAT_W{1'b0}};
        video_lock_ok <= 1'b0;
    end else begin
        stat_q[`GLPS_BIT_HPOL] <= sy[`GLPS_SY_PRES] &
                                  sy[`GLPS_SY_HPOL];
        stat_q[`GLPS_BIT_VPOL] <= sy[`GLPS_SY_PRES] &
                                  ~sy[`GLPS_SY_DIGB] &
                                  sy[`GLPS_SY_VPOL];
        stat_q[`GLPS_BIT_BLANK] <= sy[`GLPS_SY_PRES] &
                                   sy[`GLPS_SY_BLANK];
        stat_q[`GLPS_BIT_ALOCK] <= (HAS_AUDIO == 0) ? 1'b1 :
                                   sy[`GLPS_SY_ALOCK];
        stat_q[`GLPS_BIT_VLOCK] <= sy[`GLPS_SY_VLOCK] &
                                   (ref_deviation <= delta_q);
        video_lock_ok <= sy[`GLPS_SY_VLOCK] &
                         (ref_deviation <= delta_q);
    end
end

////////////////////////////////////////////////////////////////////////////
// write decode; status index accepted and dropped
always @* begin
    case (wr_idx)
        `GLPS_IDX_PHASE,
        `GLPS_IDX_DELTA,
        `GLPS_IDX_STAT,
        `GLPS_IDX_NUM_LO,
        `GLPS_IDX_NUM_HI,
        `GLPS_IDX_DEN_LO,
        `GLPS_IDX_DEN_HI: wr_err = 1'b0;
        default: wr_err = 1'b1;
    endcase
end

// read mux, reserved bits zero
always @* begin
    rd_data = 16'h0000;
    rd_err = 1'b0;
    case (rd_idx)
        `GLPS_IDX_PHASE: rd_data = phase_q;
        `GLPS_IDX_DELTA: rd_data = delta_q;
        `GLPS_IDX_STAT: rd_data = {11'h000, stat_q};
        `GLPS_IDX_NUM_LO: rd_data = half_view[`GLPS_HALF_NUM_LO];
        `GLPS_IDX_NUM_HI: rd_data = half_view[`GLPS_HALF_NUM_HI];
        `GLPS_IDX_DEN_LO: rd_data = half_view[`GLPS_HALF_DEN_LO];
        `GLPS_IDX_DEN_HI: rd_data = half_view[`GLPS_HALF_DEN_HI];
        default: rd_err = 1'b1;
    endcase
end

endmodule
`default_nettype wire
